// *** src/lcdt_timing_cfg.sv ***
// Behaviour
// - back porch lasts field plus one
// - horizontal sync lasts width field plus one
// - front porch lasts field plus one
// - dual scan: vertical size counts per panel
// - four data lines: 4-bit single, 8-bit dual
// - eight data lines: 8-bit single, 16-bit dual
// - effective FIFO depth is 512 words
// - rate select clear toggles modulation per frame
// - programmed rate toggles every value plus one lines
// - seven writable dithering patterns
// - readable 11-bit line counter counts down
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module lcdt_timing_cfg (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output lcdt_pkg::lcdt_dither_t    dither_patterns,
	output logic [15:0]               fifo_threshold_words,
	output logic [9:0]                fifo_panel_words,
	output logic [10:0]               line_counter,
	input  wire logic                 dot_clock,
	output logic                      horizontal_sync,
	output logic                      line_active,
	output logic                      modulation_output,
	output logic [3:0]                pixel_data_lines
);

	logic [31:0]                 cfg_q [lcdt_pkg::NSTORE];
	logic                        aw_ok_q;
	logic                        w_ok_q;
	logic [31:0]                 awaddr_q;
	logic [31:0]                 wdata_q;
	logic [3:0]                  wstrb_q;
	logic                        bvalid_q;
	logic [1:0]                  bresp_q;
	logic                        rvalid_q;
	logic [1:0]                  rresp_q;
	logic [31:0]                 rdata_q;
	logic                        do_write;
	logic [3:0]                  widx;
	logic [3:0]                  ridx;
	logic [31:0]                 byte_mask;
	logic [31:0]                 status_word;
	logic [3:0]                  data_lines;
	lcdt_pkg::lcdt_link_cfg_t    cfg_now;
	lcdt_pkg::lcdt_link_cfg_t    cfg_hold_q;
	logic                        cx_req_q;
	logic                        cx_ack_m_q;
	logic                        cx_ack_s_q;
	logic [10:0]                 line_cnt_a_q;
	logic                        st_ack_q;
	logic                        st_tgl_m_q;
	logic                        st_tgl_s_q;
	// Link domain
	logic                        link_rst_m_q;
	logic                        link_rstn_q;
	logic                        cx_req_m_q;
	logic                        cx_req_s_q;
	logic                        cx_ack_q;
	lcdt_pkg::lcdt_link_cfg_t    cfg_l_q;
	lcdt_pkg::lcdt_line_state_t  state_q;
	logic [11:0]                 cnt_q;
	logic [11:0]                 act_len;
	logic [10:0]                 line_cnt_q;
	logic [7:0]                  mod_cnt_q;
	logic                        mod_q;
	logic                        hsync_q;
	logic                        active_q;
	logic                        line_end;
	logic                        st_tgl_q;
	logic                        st_ack_m_q;
	logic                        st_ack_s_q;
	logic [10:0]                 st_hold_q;
	logic [3:0]                  lines_l_q;

	// Address decode; a miss answers with a slave error
	function automatic logic [3:0] reg_index(input logic [31:0] a);
		logic [3:0] idx;
		idx = lcdt_pkg::IDX_MISS;
		for (int i = 0; i < lcdt_pkg::NREG; i++)
		begin
			if (a == lcdt_pkg::REG_ADDR[i])
				idx = 4'(i);
		end
		return idx;
	endfunction

	// Write channel handshakes: address and data taken in either order
	assign s_axi_awready = !aw_ok_q && !bvalid_q;
	assign s_axi_wready  = !w_ok_q && !bvalid_q;
	assign do_write      = aw_ok_q && w_ok_q && !bvalid_q;
	assign widx          = reg_index(awaddr_q);
	assign byte_mask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
	                        {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_ok_q  <= 1'b0;
			awaddr_q <= 32'h00000000;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_ok_q  <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end
		else if (do_write)
			aw_ok_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_ok_q  <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_ok_q  <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
		else if (do_write)
			w_ok_q <= 1'b0;
	end

	// Write response, held until the master takes it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= lcdt_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= (widx < 4'(lcdt_pkg::NSTORE)) ?
			            lcdt_pkg::RESP_OKAY : lcdt_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// one writable register per pattern
	// Register storage; status word is not writable
	for (genvar g = 0; g < lcdt_pkg::NSTORE; g++)
	begin : g_reg
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				cfg_q[g] <= lcdt_pkg::REG_RESET[g];
			else if (do_write && widx == 4'(g))
				cfg_q[g] <= (cfg_q[g] & ~(byte_mask & lcdt_pkg::REG_WMASK[g]))
				          | (wdata_q & byte_mask & lcdt_pkg::REG_WMASK[g]);
		end
	end

	// four lines for 4-bit single and 8-bit dual
	// eight lines for 8-bit single and 16-bit dual
	// From the held snapshot: still while the link copies it
	always_comb
	begin
		data_lines = lcdt_pkg::LINES_FOUR;
		if (cfg_hold_q.dual_scan)
		begin
			if (cfg_hold_q.interface_width == lcdt_pkg::IFW_16BIT)
				data_lines = lcdt_pkg::LINES_EIGHT;
		end
		else if (cfg_hold_q.interface_width == lcdt_pkg::IFW_8BIT)
			data_lines = lcdt_pkg::LINES_EIGHT;
	end

	// line counter and FIFO depth readable
	always_comb
	begin
		status_word = 32'h00000000;
		status_word[10:0] = line_cnt_a_q;
		status_word[lcdt_pkg::STAT_LINES_LSB +: 4] = data_lines;
		status_word[lcdt_pkg::STAT_DEPTH_LSB +: 10] =
			lcdt_pkg::FIFO_EFFECTIVE_WORDS;
	end

	// Read channel: one read in flight, answered the next cycle
	assign s_axi_arready = !rvalid_q;
	assign ridx          = reg_index(s_axi_araddr);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= lcdt_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= lcdt_pkg::RESP_OKAY;
			if (ridx < 4'(lcdt_pkg::NSTORE))
				rdata_q <= cfg_q[ridx];
			else if (ridx == lcdt_pkg::IDX_STAT)
				rdata_q <= status_word;
			else
			begin
				rdata_q <= 32'h00000000;
				rresp_q <= lcdt_pkg::RESP_SLVERR;
			end
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// Outputs to the rest of the controller
	assign dither_patterns = '{
		pattern_half:           cfg_q[lcdt_pkg::IDX_DP12][7:0],
		pattern_four_sevenths:  cfg_q[lcdt_pkg::IDX_DP47][27:0],
		pattern_three_fifths:   cfg_q[lcdt_pkg::IDX_DP35][19:0],
		pattern_two_thirds:     cfg_q[lcdt_pkg::IDX_DP23][11:0],
		pattern_five_sevenths:  cfg_q[lcdt_pkg::IDX_DP57][27:0],
		pattern_three_quarters: cfg_q[lcdt_pkg::IDX_DP34][15:0],
		pattern_four_fifths:    cfg_q[lcdt_pkg::IDX_DP45][19:0]};
	assign fifo_threshold_words = cfg_q[lcdt_pkg::IDX_FIFO][15:0];
	// each panel sees 512 words in either scan mode
	assign fifo_panel_words     = lcdt_pkg::FIFO_EFFECTIVE_WORDS;
	assign line_counter         = line_cnt_a_q;

	// Fields gathered for the link domain
	assign cfg_now = '{
		back_porch:      cfg_q[lcdt_pkg::IDX_HTIM][lcdt_pkg::HBP_LSB +: 8],
		sync_width:      cfg_q[lcdt_pkg::IDX_HTIM][lcdt_pkg::HPW_LSB +: 6],
		front_porch:     cfg_q[lcdt_pkg::IDX_HTIM][lcdt_pkg::HFP_LSB +: 11],
		horizontal_size: cfg_q[lcdt_pkg::IDX_FRM][lcdt_pkg::HSIZE_LSB +: 11],
		vertical_size:   cfg_q[lcdt_pkg::IDX_FRM][lcdt_pkg::VSIZE_LSB +: 11],
		modulation_rate_value:
			cfg_q[lcdt_pkg::IDX_MOD][lcdt_pkg::MODULATION_RATE_VALUE_LSB +: 8],
		modulation_rate_select:
			cfg_q[lcdt_pkg::IDX_MOD][lcdt_pkg::MODULATION_RATE_SELECT_BIT],
		dual_scan:       cfg_q[lcdt_pkg::IDX_MODE][lcdt_pkg::DUAL_BIT],
		display_type:    cfg_q[lcdt_pkg::IDX_MODE][lcdt_pkg::TYPE_LSB +: 2],
		interface_width: cfg_q[lcdt_pkg::IDX_MODE][lcdt_pkg::IFW_LSB +: 2]};

	// Config snapshot handshake; hold stays still until acknowledged
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cx_ack_m_q <= 1'b0;
			cx_ack_s_q <= 1'b0;
			cx_req_q   <= 1'b0;
			cfg_hold_q <= '0;
		end
		else
		begin
			cx_ack_m_q <= cx_ack_q;
			cx_ack_s_q <= cx_ack_m_q;
			if (cx_ack_s_q == cx_req_q)
			begin
				cfg_hold_q <= cfg_now;
				cx_req_q   <= ~cx_req_q;
			end
		end
	end

	// Line counter coming back from the link domain
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_tgl_m_q   <= 1'b0;
			st_tgl_s_q   <= 1'b0;
			st_ack_q     <= 1'b0;
			line_cnt_a_q <= 11'h000;
		end
		else
		begin
			st_tgl_m_q <= st_tgl_q;
			st_tgl_s_q <= st_tgl_m_q;
			if (st_tgl_s_q != st_ack_q)
			begin
				line_cnt_a_q <= st_hold_q;
				st_ack_q     <= st_tgl_s_q;
			end
		end
	end

	// Link reset released in the dot clock domain
	always_ff @(posedge dot_clock)
	begin
		link_rst_m_q <= aresetn;
		link_rstn_q  <= link_rst_m_q;
	end

	// Link side of the snapshot handshake
	always_ff @(posedge dot_clock)
	begin
		if (!link_rstn_q)
		begin
			cx_req_m_q <= 1'b0;
			cx_req_s_q <= 1'b0;
			cx_ack_q   <= 1'b0;
			cfg_l_q    <= '0;
			lines_l_q  <= lcdt_pkg::LINES_FOUR;
		end
		else
		begin
			cx_req_m_q <= cx_req_q;
			cx_req_s_q <= cx_req_m_q;
			if (cx_req_s_q != cx_ack_q)
			begin
				cfg_l_q   <= cfg_hold_q;
				lines_l_q <= data_lines;
				cx_ack_q  <= cx_req_s_q;
			end
		end
	end

	// STN size is cycles minus one; TFT size is cycles
	assign act_len = (cfg_l_q.display_type == lcdt_pkg::TYPE_TFT) ?
	                 {1'b0, cfg_l_q.horizontal_size} :
	                 {1'b0, cfg_l_q.horizontal_size} + 12'h001;
	// Parts end at or past their limit: a smaller value written
	// mid-line cuts that part short instead of wrapping the counter
	assign line_end = (state_q == lcdt_pkg::LS_FRONT) &&
	                  (cnt_q >= {1'b0, cfg_l_q.front_porch});

	// sync, back porch, active, front porch
	always_ff @(posedge dot_clock)
	begin
		if (!link_rstn_q)
		begin
			state_q <= lcdt_pkg::LS_SYNC;
			cnt_q   <= 12'h000;
		end
		else
		begin
			cnt_q <= cnt_q + 12'h001;
			unique case (state_q)
				lcdt_pkg::LS_SYNC:
					if (cnt_q >= {6'h00, cfg_l_q.sync_width})
					begin
						state_q <= lcdt_pkg::LS_BACK;
						cnt_q   <= 12'h000;
					end
				lcdt_pkg::LS_BACK:
					if (cnt_q >= {4'h0, cfg_l_q.back_porch})
					begin
						state_q <= (act_len == 12'h000) ?
						           lcdt_pkg::LS_FRONT : lcdt_pkg::LS_ACTIVE;
						cnt_q   <= 12'h000;
					end
				lcdt_pkg::LS_ACTIVE:
					if (cnt_q + 12'h001 >= act_len)
					begin
						state_q <= lcdt_pkg::LS_FRONT;
						cnt_q   <= 12'h000;
					end
				lcdt_pkg::LS_FRONT:
					if (line_end)
					begin
						state_q <= lcdt_pkg::LS_SYNC;
						cnt_q   <= 12'h000;
					end
			endcase
		end
	end

	// Registered panel strobes, one dot clock behind the state
	always_ff @(posedge dot_clock)
	begin
		if (!link_rstn_q)
		begin
			hsync_q  <= 1'b0;
			active_q <= 1'b0;
		end
		else
		begin
			hsync_q  <= (state_q == lcdt_pkg::LS_SYNC);
			active_q <= (state_q == lcdt_pkg::LS_ACTIVE);
		end
	end

	// down count from vertical size to zero
	// in dual scan the count is per panel
	always_ff @(posedge dot_clock)
	begin
		if (!link_rstn_q)
			line_cnt_q <= 11'h000;
		else if (line_end)
			line_cnt_q <= (line_cnt_q == 11'h000) ?
			              cfg_l_q.vertical_size : line_cnt_q - 11'h001;
	end

	// toggle every rate value plus one lines with select set, once a frame with select clear
	always_ff @(posedge dot_clock)
	begin
		if (!link_rstn_q)
		begin
			mod_q     <= 1'b0;
			mod_cnt_q <= 8'h00;
		end
		else if (line_end)
		begin
			if (cfg_l_q.modulation_rate_select)
			begin
				if (mod_cnt_q >= cfg_l_q.modulation_rate_value)
				begin
					mod_q     <= ~mod_q;
					mod_cnt_q <= 8'h00;
				end
				else
					mod_cnt_q <= mod_cnt_q + 8'h01;
			end
			else
			begin
				mod_cnt_q <= 8'h00;
				if (line_cnt_q == 11'h000)
					mod_q <= ~mod_q;
			end
		end
	end

	// Counter publish; skipped lines are fine, software polls
	always_ff @(posedge dot_clock)
	begin
		if (!link_rstn_q)
		begin
			st_ack_m_q <= 1'b0;
			st_ack_s_q <= 1'b0;
			st_tgl_q   <= 1'b0;
			st_hold_q  <= 11'h000;
		end
		else
		begin
			st_ack_m_q <= st_ack_q;
			st_ack_s_q <= st_ack_m_q;
			if (st_ack_s_q == st_tgl_q)
			begin
				st_hold_q <= line_cnt_q;
				st_tgl_q  <= ~st_tgl_q;
			end
		end
	end

	assign horizontal_sync   = hsync_q;
	assign line_active       = active_q;
	assign modulation_output = mod_q;
	assign pixel_data_lines  = lines_l_q;

endmodule
`default_nettype wire

// *** common/lcdt_pkg.sv ***
package lcdt_pkg;
	// Register map: stored registers first, status word last
	localparam int          NREG     = 13;
	localparam int          NSTORE   = 12;
	localparam logic [3:0]  IDX_HTIM = 4'h0;
	localparam logic [3:0]  IDX_FRM  = 4'h1;
	localparam logic [3:0]  IDX_FIFO = 4'h2;
	localparam logic [3:0]  IDX_MOD  = 4'h3;
	localparam logic [3:0]  IDX_DP12 = 4'h4;
	localparam logic [3:0]  IDX_DP47 = 4'h5;
	localparam logic [3:0]  IDX_DP35 = 4'h6;
	localparam logic [3:0]  IDX_DP23 = 4'h7;
	localparam logic [3:0]  IDX_DP57 = 4'h8;
	localparam logic [3:0]  IDX_DP34 = 4'h9;
	localparam logic [3:0]  IDX_DP45 = 4'ha;
	localparam logic [3:0]  IDX_MODE = 4'hb;
	localparam logic [3:0]  IDX_STAT = 4'hc;
	localparam logic [3:0]  IDX_MISS = 4'hf;
	localparam logic [31:0] REG_ADDR [NREG] = '{
		32'h0060080c, 32'h00600810, 32'h00600814, 32'h00600818,
		32'h0060081c, 32'h00600820, 32'h00600824, 32'h00600828,
		32'h0060082c, 32'h00600830, 32'h00600834, 32'h00600870,
		32'h00600874};
	// Writable bits; reserved bits stay zero
	localparam logic [31:0] REG_WMASK [NSTORE] = '{
		32'hffe03fff, 32'hffe007ff, 32'h0000ffff, 32'h800000ff,
		32'h000000ff, 32'h0fffffff, 32'h000fffff, 32'h00000fff,
		32'h0fffffff, 32'h0000ffff, 32'h000fffff, 32'h0000001f};
	localparam logic [31:0] REG_RESET [NSTORE] = '{
		32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h000000a5, 32'h05af0fa5, 32'h000a5a5f, 32'h00000a5f,
		32'h0faf5fa5, 32'h0000faf5, 32'h000faf5f, 32'h00000000};
	// Field positions
	localparam int HBP_LSB   = 0;
	localparam int HPW_LSB   = 8;
	localparam int HFP_LSB   = 21;
	localparam int VSIZE_LSB = 0;
	localparam int HSIZE_LSB = 21;
	localparam int MODULATION_RATE_VALUE_LSB  = 0;
	localparam int MODULATION_RATE_SELECT_BIT = 31;
	localparam int DUAL_BIT  = 0;
	localparam int TYPE_LSB  = 1;
	localparam int IFW_LSB   = 3;
	localparam int STAT_LINES_LSB = 16;
	localparam int STAT_DEPTH_LSB = 20;
	// Encodings and sizes
	localparam logic [1:0]  TYPE_TFT    = 2'h2;
	localparam logic [1:0]  IFW_4BIT    = 2'h0;
	localparam logic [1:0]  IFW_8BIT    = 2'h1;
	localparam logic [1:0]  IFW_16BIT   = 2'h2;
	localparam logic [3:0]  LINES_FOUR  = 4'h4;
	localparam logic [3:0]  LINES_EIGHT = 4'h8;
	localparam logic [9:0]  FIFO_EFFECTIVE_WORDS = 10'h200;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0]  back_porch;
		logic [5:0]  sync_width;
		logic [10:0] front_porch;
		logic [10:0] horizontal_size;
		logic [10:0] vertical_size;
		logic [7:0]  modulation_rate_value;
		logic        modulation_rate_select;
		logic        dual_scan;
		logic [1:0]  display_type;
		logic [1:0]  interface_width;
	} lcdt_link_cfg_t;

	typedef struct packed {
		logic [7:0]  pattern_half;
		logic [27:0] pattern_four_sevenths;
		logic [19:0] pattern_three_fifths;
		logic [11:0] pattern_two_thirds;
		logic [27:0] pattern_five_sevenths;
		logic [15:0] pattern_three_quarters;
		logic [19:0] pattern_four_fifths;
	} lcdt_dither_t;

	typedef enum logic [1:0] {
		LS_SYNC,
		LS_BACK,
		LS_ACTIVE,
		LS_FRONT
	} lcdt_line_state_t;
endpackage

// *** testbench/lcdt_timing_cfg_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcdt_chk (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   dot_clock,
	input  wire logic                   s_axi_bvalid,
	input  wire logic                   horizontal_sync,
	input  wire logic                   line_active,
	input  wire logic                   modulation_output,
	input  wire logic [3:0]             pixel_data_lines,
	input  wire logic [9:0]             fifo_panel_words,
	input  wire logic [10:0]            line_counter,
	input  wire lcdt_pkg::lcdt_dither_t dither_patterns
);
	a_back_after_sync:
	assert property (@(posedge dot_clock) disable iff (!aresetn)
		$fell(horizontal_sync) |-> !line_active) else $error("no back porch");
	a_idle_before_px:
	assert property (@(posedge dot_clock) disable iff (!aresetn)
		$rose(line_active) |-> !$past(horizontal_sync)) else $error("no idle");
	a_front_after_px:
	assert property (@(posedge dot_clock) disable iff (!aresetn)
		$fell(line_active) |-> !horizontal_sync) else $error("no front porch");
	a_sync_after_idle:
	assert property (@(posedge dot_clock) disable iff (!aresetn)
		$rose(horizontal_sync) |-> !$past(line_active)) else $error("bad order");
	a_no_overlap:
	assert property (@(posedge dot_clock) disable iff (!aresetn)
		horizontal_sync |-> !line_active) else $error("sync with pixels");
	a_data_lines:
	assert property (@(posedge dot_clock) disable iff (!aresetn)
		pixel_data_lines == lcdt_pkg::LINES_FOUR
		|| pixel_data_lines == lcdt_pkg::LINES_EIGHT) else $error("bad lines");
	a_fifo_depth:
	assert property (@(posedge aclk) disable iff (!aresetn)
		fifo_panel_words == lcdt_pkg::FIFO_EFFECTIVE_WORDS) else $error("depth");
	a_count_down:
	assert property (@(posedge aclk) disable iff (!aresetn)
		line_counter != $past(line_counter) |-> line_counter < $past(line_counter)
		|| $past(line_counter) == 11'h000) else $error("counter not down");
	// patterns change only by a write
	a_pattern_write:
	assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(dither_patterns) |-> $rose(s_axi_bvalid)) else $error("pattern");
	// Main scenarios reached
	c_active: cover property (@(posedge dot_clock) $rose(line_active));
	c_mod: cover property (@(posedge dot_clock) $changed(modulation_output));
	c_pat: cover property (@(posedge aclk) $changed(dither_patterns));
endmodule
bind lcdt_timing_cfg lcdt_chk i_chk (
	.aclk(aclk), .aresetn(aresetn), .dot_clock(dot_clock),
	.s_axi_bvalid(s_axi_bvalid), .horizontal_sync(horizontal_sync),
	.line_active(line_active), .modulation_output(modulation_output),
	.pixel_data_lines(pixel_data_lines), .fifo_panel_words(fifo_panel_words),
	.line_counter(line_counter), .dither_patterns(dither_patterns)
);
`default_nettype wire

// *** testbench/lcdt_panel_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcdt_panel_model (
	input  wire logic dot_clock,
	input  wire logic horizontal_sync,
	input  wire logic line_active,
	input  wire logic modulation_output
);
	int         seg_len [4];
	int         run_q, lines_q, mod_gap, bad_order;
	logic [1:0] seg, seg_q;
	logic       seen_q, mod_q, start;
	// Part of line: 0 sync, 1 back, 2 active, 3 front
	assign seg = horizontal_sync ? 2'h0 : line_active ? 2'h2
		: seen_q ? 2'h3 : 2'h1;
	assign start = (seg == 2'h0) && (seg_q != 2'h0);
	initial
	begin
		run_q = 0;
		lines_q = 0;
		mod_gap = 0;
		bad_order = 0;
		seen_q = 1'b0;
	end
	always @(posedge dot_clock)
	begin
		if (seg != seg_q)
		begin
			seg_len[seg_q] <= run_q;
			run_q <= 1;
			bad_order <= bad_order + int'(seg != seg_q + 2'h1);
		end
		else
			run_q <= run_q + 1;
		seg_q <= seg;
		seen_q <= horizontal_sync ? 1'b0 : (seen_q | line_active);
	end
	// lines between toggles; aligned either side of sync
	always @(posedge dot_clock)
	begin
		mod_q <= modulation_output;
		if (modulation_output != mod_q)
		begin
			mod_gap <= lines_q;
			lines_q <= int'(start);
		end
		else if (start)
			lines_q <= lines_q + 1;
	end
endmodule
`default_nettype wire

// *** testbench/lcdt_timing_cfg_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcdt_timing_cfg_bench;
	localparam int LIMIT = 20000;
	logic                   aclk, aresetn, dot_clock;
	logic [31:0]            s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                   s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic                   s_axi_rready, horizontal_sync, line_active;
	logic                   modulation_output;
	logic [1:0]             s_axi_bresp, s_axi_rresp;
	logic [3:0]             s_axi_wstrb, pixel_data_lines;
	lcdt_pkg::lcdt_dither_t dither_patterns;
	logic [15:0]            fifo_threshold_words;
	logic [9:0]             fifo_panel_words;
	logic [10:0]            line_counter, stn_hoz;
	int                     n_fail, total_checks, cycles;

	lcdt_timing_cfg i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .dither_patterns(dither_patterns),
		.fifo_threshold_words(fifo_threshold_words),
		.fifo_panel_words(fifo_panel_words), .line_counter(line_counter),
		.dot_clock(dot_clock), .horizontal_sync(horizontal_sync),
		.line_active(line_active), .modulation_output(modulation_output),
		.pixel_data_lines(pixel_data_lines));
	lcdt_panel_model i_pan (.dot_clock(dot_clock),
		.horizontal_sync(horizontal_sync), .line_active(line_active),
		.modulation_output(modulation_output));

	// Register clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Link clock, 15 ns, edges never meet the register clock
	initial
	begin
		dot_clock = 1'b0;
		#2;
		forever
		begin
			#7 dot_clock = 1'b1;
			#8 dot_clock = 1'b0;
		end
	end
	// Watchdog against a hung handshake
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			n_fail = n_fail + 1;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, exp, input string what);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen,
				exp);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic w(input logic [3:0] idx, input logic [31:0] d);
		logic [1:0] r;
		wr(lcdt_pkg::REG_ADDR[idx], d, r);
		chk(32'(r), 32'(lcdt_pkg::RESP_OKAY), "write response");
	endtask
	// Highest line counter value seen over a while
	task automatic top(output logic [10:0] mx);
		mx = 11'h000;
		repeat (300)
		begin
			@(posedge aclk);
			if (line_counter > mx)
				mx = line_counter;
		end
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < lcdt_pkg::NSTORE; i++)
		begin
			rd(lcdt_pkg::REG_ADDR[i], d, r);
			chk(d, lcdt_pkg::REG_RESET[i], "reset value");
		end
		rd(32'h006008f0, d, r);
		chk(d, 32'h0, "unmapped data");
		chk(32'(r), 32'(lcdt_pkg::RESP_SLVERR), "unmapped read");
		wr(32'h006008f0, 32'h1, r);
		chk(32'(r), 32'(lcdt_pkg::RESP_SLVERR), "unmapped write");
		wr(lcdt_pkg::REG_ADDR[lcdt_pkg::IDX_STAT], 32'h7ff, r);
		chk(32'(r), 32'(lcdt_pkg::RESP_SLVERR), "status write");
		$display("test regs done");
	endtask
	task automatic t_dither();
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = lcdt_pkg::IDX_DP12; i <= lcdt_pkg::IDX_DP45; i++)
		begin
			w(4'(i), 32'hffffffff);
			rd(lcdt_pkg::REG_ADDR[i], d, r);
			chk(d, lcdt_pkg::REG_WMASK[i], "pattern readback");
		end
		chk(32'(&dither_patterns), 32'h1, "pattern port");
		$display("test dither done");
	endtask
	// Sync 3, back 4, front 5 cycles; three lines a frame
	task automatic t_line(input logic [4:0] mode, input logic [10:0] hoz,
		input int act);
		logic [10:0] mx;
		int          b0;
		w(lcdt_pkg::IDX_MODE, {27'h0, mode});
		w(lcdt_pkg::IDX_HTIM, {11'h004, 7'h00, 6'h02, 8'h03});
		w(lcdt_pkg::IDX_FRM, {hoz, 10'h000, 11'h002});
		top(mx);
		b0 = i_pan.bad_order;
		top(mx);
		chk(i_pan.seg_len[0], 3, "sync length");
		chk(i_pan.seg_len[1], 4, "back porch");
		chk(i_pan.seg_len[2], act, "active length");
		chk(i_pan.seg_len[3], 5, "front porch");
		chk(i_pan.bad_order, b0, "line order");
		chk(32'(mx), 32'h2, "line counter top");
		$display("test line done");
	endtask
	task automatic t_lines();
		logic [4:0]  md [4] = '{5'h00, 5'h09, 5'h08, 5'h11};
		logic [3:0]  ex [4] = '{4'h4, 4'h4, 4'h8, 4'h8};
		logic [10:0] mx;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 4; i++)
		begin
			w(lcdt_pkg::IDX_MODE, {27'h0, md[i]});
			top(mx);
			chk(32'(pixel_data_lines), 32'(ex[i]), "data lines");
			rd(lcdt_pkg::REG_ADDR[lcdt_pkg::IDX_STAT], d, r);
			chk(32'(d[19:16]), 32'(ex[i]), "status lines");
			chk(32'(mx), 32'h2, "lines per panel");
		end
		$display("test lines done");
	endtask
	task automatic t_mod();
		w(lcdt_pkg::IDX_MODE, 32'h0000000a);
		w(lcdt_pkg::IDX_MOD, 32'h00000000);
		repeat (1500) @(posedge aclk);
		chk(i_pan.mod_gap, 3, "toggle per frame");
		w(lcdt_pkg::IDX_MOD, 32'h80000004);
		repeat (1500) @(posedge aclk);
		chk(i_pan.mod_gap, 5, "toggle by rate");
		$display("test modulation done");
	endtask
	task automatic t_fifo();
		logic [15:0] th;
		logic [31:0] d;
		logic [1:0]  r;
		// burst of 8 words, field holds 7
		th = 16'(512 - (2 * (7 + 1) + 3));
		w(lcdt_pkg::IDX_FIFO, {16'h0000, th});
		chk(32'(fifo_threshold_words), 32'(th), "threshold");
		chk(32'(fifo_panel_words), 32'h200, "panel depth");
		rd(lcdt_pkg::REG_ADDR[lcdt_pkg::IDX_STAT], d, r);
		chk(32'(d[29:20]), 32'h200, "status depth");
		$display("test fifo done");
	endtask

	initial
	begin
		n_fail = 0;
		total_checks = 0;
		cycles = 0;
		aresetn = 1'b0;
		s_axi_awaddr = 32'h0;
		s_axi_wdata = 32'h0;
		s_axi_araddr = 32'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_wstrb = 4'hf;
		// seven colour pixels on eight lines, rounded up
		stn_hoz = 11'((3 * 7 + 7) / 8 - 1);
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_dither();
		t_line(5'h04, 11'h00a, 10);
		t_line(5'h0a, stn_hoz, int'(stn_hoz) + 1);
		t_lines();
		t_mod();
		t_fifo();
		end_of_test();
	end
endmodule
`default_nettype wire
